// File: hw/bfp_bridge.sv
// bfp_bridge: gate drive for one h-bridge with dead interval on every change
// assumes mode and direction come from the chopper on the same clock
`timescale 1ns/1ps
module bfp_bridge
  import bfp_pkg::*;
#(
  parameter int unsigned DEAD = DEAD_CYC
) (
  input  wire logic      sys_clk,
  input  wire logic      rst_n,
  input  wire logic      clk_en,
  input  wire logic      force_off,
  input  wire bfp_mode_e mode,
  input  wire logic      dir,
  output logic [3:0]     gates
);
  localparam int unsigned DW = $clog2(DEAD + 1);

  // gate order: {low_side_two, low_side_one, high_side_two, high_side_one}
  function automatic logic [3:0] decode(input bfp_mode_e m, input logic d);
    logic [3:0] g;
    g = GATES_OFF;
    unique case (m)
      BFP_CHARGE: g = d ? 4'h6 : 4'h9;
      BFP_FAST:   g = d ? 4'h9 : 4'h6;
      BFP_SLOW:   g = 4'hc;
      BFP_OFF:    g = GATES_OFF;
    endcase
    return g;
  endfunction : decode

  logic [3:0]    want;
  logic [3:0]    gates_reg;
  logic [3:0]    gates_next;
  logic [DW-1:0] dead_reg;
  logic [DW-1:0] dead_next;

  assign want = force_off ? GATES_OFF : decode(mode, dir);

  always_comb begin
    gates_next = gates_reg;
    dead_next  = dead_reg;
    if (want != gates_reg) begin
      if (gates_reg != GATES_OFF) begin
        gates_next = GATES_OFF;
        dead_next  = DW'(DEAD);
      end else if (dead_reg != '0) begin
        dead_next = dead_reg - DW'(1);
      end else begin
        gates_next = want;
      end
    end else if (dead_reg != '0) begin
      dead_next = dead_reg - DW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gates_reg <= GATES_OFF;
      dead_reg  <= '0;
    end else if (clk_en) begin
      gates_reg <= gates_next;
      dead_reg  <= dead_next;
    end
  end

  assign gates = gates_reg;
endmodule : bfp_bridge

// File: hw/bfp_filter.sv
// bfp_filter: qualifies a raw fault level by a run of consecutive high cycles
// assumes raw input is already synchronised to sys_clk
`timescale 1ns/1ps
module bfp_filter
  import bfp_pkg::*;
#(
  parameter int unsigned COUNT = 8
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic raw,
  output logic      qualified
);
  localparam int unsigned CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          q_reg;
  logic          q_next;

  always_comb begin
    cnt_next = cnt_reg;
    q_next   = q_reg;
    if (!raw) begin
      cnt_next = '0;
      q_next   = 1'b0;
    end else if (cnt_reg == LAST) begin
      q_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      q_reg   <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      q_reg   <= q_next;
    end
  end

  assign qualified = q_reg;
endmodule : bfp_filter

// File: hw/bfp_pkg.sv
// bfp_pkg: constants shared by the bridge fault protection logic
// assumes a 100 MHz system clock; all times are turned into cycle counts here
package bfp_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // filter times in nanoseconds (supply-low in picoseconds), least times rounded up to whole cycles
  localparam int unsigned TSD_FILT_NS  = 5000;
  localparam int unsigned TSD_FILT_CYC = (TSD_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SUPPLY_LOW_LOCKOUT_FILT_PS  = 1410000;
  localparam int unsigned SUPPLY_LOW_LOCKOUT_FILT_CYC = (SUPPLY_LOW_LOCKOUT_FILT_PS / 1000 * CLK_MHZ + 999) / 1000;
  // overcurrent blanking is not printed; plain default
  localparam int unsigned OC_BLANK_NS  = 1000;
  localparam int unsigned OC_BLANK_CYC = (OC_BLANK_NS * CLK_MHZ + 999) / 1000;
  // cross-conduction dead interval; plain default
  localparam int unsigned DEAD_NS  = 200;
  localparam int unsigned DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;

  // chopping: oscillator divided by sixteen
  localparam int unsigned CHOP_DIV = 16;
  // internal oscillator 914 kHz; sys_clk cycles per oscillator tick, rounded down
  localparam int unsigned OSC_INT_KHZ = 914;
  localparam int unsigned OSC_INT_DIV = (CLK_MHZ * 1000) / OSC_INT_KHZ;
  localparam int unsigned CHOP_INT_KHZ_X10 = 571;

  localparam logic [3:0] GATES_OFF = 4'h0;

  typedef enum logic [1:0] {
    BFP_CHARGE = 2'b00,
    BFP_FAST   = 2'b01,
    BFP_SLOW   = 2'b10,
    BFP_OFF    = 2'b11
  } bfp_mode_e;

endpackage : bfp_pkg

// File: hw/bfp_top.sv
// bfp_top: protection and output-stage control of a two-channel stepper bridge
// assumes fault and supply indications are asynchronous comparator levels
`timescale 1ns/1ps
module bfp_top
  import bfp_pkg::*;
#(
  parameter int unsigned TSD_CYC   = TSD_FILT_CYC,
  parameter int unsigned OC_CYC    = OC_BLANK_CYC,
  parameter int unsigned SUPPLY_LOW_LOCKOUT_CYC  = SUPPLY_LOW_LOCKOUT_FILT_CYC,
  parameter int unsigned OSC_DIV   = OSC_INT_DIV
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       thermal_shutdown,
  input  wire logic       overcurrent_detect_a,
  input  wire logic       overcurrent_detect_b,
  input  wire logic       supply_low,
  input  wire logic       sleep,
  input  wire logic       osc_set_pin,
  input  wire logic       osc_ext_tick,
  input  wire logic       bridge_enable,
  input  wire logic       dir_a,
  input  wire logic       dir_b,
  input  wire logic       above_limit_a,
  input  wire logic       above_limit_b,
  input  wire logic       fast_phase_a,
  input  wire logic       fast_phase_b,
  output logic            fault_flag_n_o,
  output logic            fault_flag_n_oe,
  output logic            thermal_flag_n_o,
  output logic            thermal_flag_n_oe,
  output logic            supply_low_lockout,
  output logic            chop_tick,
  output logic [3:0]      gates_a,
  output logic [3:0]      gates_b
);
  localparam int unsigned OW = $clog2(OSC_DIV + 1);

  // two-flop synchronisers for the fault, supply, sleep and oscillator inputs
  // clk_en freezes these too: a pin pulse shorter than a freeze is lost
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] meta_reg;
  logic [NSYNC-1:0] sync_reg;
  // the external tick passes the same two flops, so it must run below sys_clk / 2
  assign raw_in = {osc_ext_tick,
                   osc_set_pin,
                   sleep,
                   supply_low,
                   overcurrent_detect_b,
                   overcurrent_detect_a,
                   thermal_shutdown};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (clk_en) begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
    end
  end

  logic tsd_s;
  logic oca_s;
  logic ocb_s;
  logic uv_s;
  logic sleep_s;
  logic osc_pin_s;
  logic ext_tick_s;
  assign tsd_s      = sync_reg[0];
  assign oca_s      = sync_reg[1];
  assign ocb_s      = sync_reg[2];
  assign uv_s       = sync_reg[3];
  assign sleep_s    = sync_reg[4];
  assign osc_pin_s  = sync_reg[5];
  assign ext_tick_s = sync_reg[6];

  logic tsd_q;
  bfp_filter #(.COUNT(TSD_CYC)) u_tsd_filt (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .raw       (tsd_s),
    .qualified (tsd_q)
  );

  // overcurrent blanking per channel
  // both channels feed one latch, so the flags cannot tell a from b
  logic oca_q;
  logic ocb_q;
  bfp_filter #(.COUNT(OC_CYC)) u_oca_filt (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .raw       (oca_s),
    .qualified (oca_q)
  );
  bfp_filter #(.COUNT(OC_CYC)) u_ocb_filt (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .raw       (ocb_s),
    .qualified (ocb_q)
  );

  // supply-low filter
  // filters stay on rst_n only, so a fault can qualify again right after recovery
  logic uv_q;
  bfp_filter #(.COUNT(SUPPLY_LOW_LOCKOUT_CYC)) u_uv_filt (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .raw       (uv_s),
    .qualified (uv_q)
  );

  // latched faults: a trip in the same cycle as a sleep clear still latches,
  // so a fault that persists through sleep is never lost
  logic tsd_lat_reg;
  logic tsd_lat_next;
  logic oc_lat_reg;
  logic oc_lat_next;

  always_comb begin
    tsd_lat_next = tsd_lat_reg;
    oc_lat_next  = oc_lat_reg;
    if (sleep_s) begin
      tsd_lat_next = 1'b0;
      oc_lat_next  = 1'b0;
    end
    if (tsd_q) begin
      tsd_lat_next = 1'b1;
    end
    if (oca_q || ocb_q) begin
      oc_lat_next = 1'b1;
    end
    if (uv_q) begin
      tsd_lat_next = 1'b0;
      oc_lat_next  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tsd_lat_reg <= 1'b0;
      oc_lat_reg  <= 1'b0;
    end else if (clk_en) begin
      tsd_lat_reg <= tsd_lat_next;
      oc_lat_reg  <= oc_lat_next;
    end
  end

  // open-drain flags: the level is always low, only the enable moves;
  // the host pull-up supplies the released high level
  // general flag on either fault
  assign fault_flag_n_o    = 1'b0;
  assign fault_flag_n_oe   = tsd_lat_reg | oc_lat_reg;
  assign thermal_flag_n_o  = 1'b0;
  assign thermal_flag_n_oe = tsd_lat_reg;
  assign supply_low_lockout = uv_q;

  // oscillator: internal divider when pin is open or grounded, else external ticks
  // the integer divide rounds the internal oscillator slightly fast
  logic [OW-1:0] osc_cnt_reg;
  logic [OW-1:0] osc_cnt_next;
  logic          ext_prev_reg;
  logic [3:0]    chop_cnt_reg;
  logic [3:0]    chop_cnt_next;
  logic          osc_tick;
  logic          chop_next;
  logic          chop_reg;

  always_comb begin
    osc_cnt_next = osc_cnt_reg;
    osc_tick     = 1'b0;
    if (!osc_pin_s) begin
      if (osc_cnt_reg == OW'(OSC_DIV - 1)) begin
        osc_cnt_next = '0;
        osc_tick     = 1'b1;
      end else begin
        osc_cnt_next = osc_cnt_reg + OW'(1);
      end
    end else begin
      osc_cnt_next = '0;
      // external ticks count on rising edges only
      osc_tick     = ext_tick_s & ~ext_prev_reg;
    end
    chop_cnt_next = osc_tick ? chop_cnt_reg + 4'h1 : chop_cnt_reg;
    chop_next     = osc_tick && (chop_cnt_reg == 4'(CHOP_DIV - 1));
    // logic held reset in lockout
    // restarting here makes the first period after recovery a whole one
    if (uv_q) begin
      osc_cnt_next  = '0;
      chop_cnt_next = 4'h0;
      chop_next     = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_reg  <= '0;
      ext_prev_reg <= 1'b0;
      chop_cnt_reg <= 4'h0;
      chop_reg     <= 1'b0;
    end else if (clk_en) begin
      osc_cnt_reg  <= osc_cnt_next;
      ext_prev_reg <= ext_tick_s;
      chop_cnt_reg <= chop_cnt_next;
      chop_reg     <= chop_next;
    end
  end

  assign chop_tick = chop_reg;

  // per-channel decay mode: charge until above limit, then fast or slow decay;
  // a new chop period restarts charge
  // there is no off-time timer: a decay phase lasts until the next chop tick,
  // and each restart costs one dead interval in the bridge
  bfp_mode_e mode_reg [2];
  bfp_mode_e mode_next [2];
  logic [1:0] above;
  logic [1:0] fastp;
  logic       stop_all;
  assign above = {above_limit_b, above_limit_a};
  assign fastp = {fast_phase_b, fast_phase_a};
  // all outputs off
  // one stop for both channels: a fault on either bridge parks both
  assign stop_all = uv_q
                  | tsd_lat_reg
                  | oc_lat_reg
                  | sleep_s
                  | ~bridge_enable;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mode_next[i] = mode_reg[i];
      if (stop_all) begin
        mode_next[i] = BFP_OFF;
      end else if (chop_reg || mode_reg[i] == BFP_OFF) begin
        mode_next[i] = BFP_CHARGE;
      end else if (mode_reg[i] == BFP_CHARGE && above[i]) begin
        mode_next[i] = fastp[i] ? BFP_FAST : BFP_SLOW;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg[0] <= BFP_OFF;
      mode_reg[1] <= BFP_OFF;
    end else if (clk_en) begin
      mode_reg[0] <= mode_next[0];
      mode_reg[1] <= mode_next[1];
    end
  end

  // each bridge applies its own dead interval; both take the shared stop
  bfp_bridge u_bridge_a (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .force_off (stop_all),
    .mode      (mode_reg[0]),
    .dir       (dir_a),
    .gates     (gates_a)
  );

  bfp_bridge u_bridge_b (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .force_off (stop_all),
    .mode      (mode_reg[1]),
    .dir       (dir_b),
    .gates     (gates_b)
  );
endmodule : bfp_top

// File: sim/bfp_load_model.sv
// bfp_load_model: host side of the two open-drain flag lines
// assumes pull-ups to the logic supply on both lines
`timescale 1ns/1ps
module bfp_load_model (
  input  wire logic fault_flag_n_o,
  input  wire logic fault_flag_n_oe,
  input  wire logic thermal_flag_n_o,
  input  wire logic thermal_flag_n_oe,
  output logic      fault_line,
  output logic      thermal_line
);
  // a released line floats up to the pull-up level
  assign fault_line   = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
  assign thermal_line = thermal_flag_n_oe ? thermal_flag_n_o : 1'b1;
endmodule : bfp_load_model

// File: sim/bfp_top_properties.sv
// bfp_top_properties: port timing of the bridge protection block
// assumes binding into bfp_top, parameters handed on
`timescale 1ns/1ps
module bfp_top_properties
  import bfp_pkg::*;
#(
  parameter int unsigned TSD_CYC  = TSD_FILT_CYC,
  parameter int unsigned SUPPLY_LOW_LOCKOUT_CYC = SUPPLY_LOW_LOCKOUT_FILT_CYC,
  parameter int unsigned OSC_DIV  = OSC_INT_DIV
) (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic       thermal_shutdown,
  input wire logic       supply_low,
  input wire logic       sleep,
  input wire logic       osc_set_pin,
  input wire logic       fault_flag_n_o,
  input wire logic       fault_flag_n_oe,
  input wire logic       thermal_flag_n_o,
  input wire logic       thermal_flag_n_oe,
  input wire logic       supply_low_lockout,
  input wire logic       chop_tick,
  input wire logic [3:0] gates_a,
  input wire logic [3:0] gates_b
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] gap_reg, gap_next;
  logic        clean_reg, clean_next;
  // an interval touched by sleep, lockout or the outside clock is not timed
  always_comb begin
    gap_next   = chop_tick ? 16'h0 : gap_reg + 16'h1;
    clean_next = (supply_low_lockout | sleep | osc_set_pin | !clk_en) ? 1'b0 :
                 (chop_tick ? 1'b1 : clean_reg);
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg   <= 16'h0;
      clean_reg <= 1'b0;
    end else begin
      gap_reg   <= gap_next;
      clean_reg <= clean_next;
    end
  end
  property p_flag_low; fault_flag_n_o == 1'b0 && thermal_flag_n_o == 1'b0; endproperty
  a_flag_low: assert property (p_flag_low) else $error("flag drives high");
  property p_thermal_in_fault; thermal_flag_n_oe |-> fault_flag_n_oe; endproperty
  a_thermal_in_fault: assert property (p_thermal_in_fault) else $error("fault flag idle");
  property p_fault_off; fault_flag_n_oe |=> gates_a == 4'h0 && gates_b == 4'h0; endproperty
  a_fault_off: assert property (p_fault_off) else $error("gates on in fault");
  property p_lock_off;
    supply_low_lockout ##1 supply_low_lockout |-> !fault_flag_n_oe && gates_a == 4'h0 &&
      gates_b == 4'h0;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("lockout not forcing off");
  property p_legal;
    gates_a inside {4'h0, 4'h6, 4'h9, 4'hc} && gates_b inside {4'h0, 4'h6, 4'h9, 4'hc};
  endproperty
  a_legal: assert property (p_legal) else $error("illegal gate pattern");
  property p_dead;
    ($changed(gates_a) && gates_a != 4'h0 |-> $past(gates_a, 2) == 4'h0) and
    ($changed(gates_b) && gates_b != 4'h0 |-> $past(gates_b, 2) == 4'h0);
  endproperty
  a_dead: assert property (p_dead) else $error("no dead interval");
  property p_chop; chop_tick && clean_reg |-> gap_reg == 16'(CHOP_DIV * OSC_DIV - 1); endproperty
  a_chop: assert property (p_chop) else $error("chop period wrong");
  property p_tsd_filt;
    $rose(thermal_flag_n_oe) |-> $past(thermal_shutdown, 4) &&
      $past(thermal_shutdown, TSD_CYC + 3);
  endproperty
  a_tsd_filt: assert property (p_tsd_filt) else $error("thermal unfiltered");
  property p_uv_filt;
    $rose(supply_low_lockout) |-> $past(supply_low, 3) && $past(supply_low, SUPPLY_LOW_LOCKOUT_CYC + 2);
  endproperty
  a_uv_filt: assert property (p_uv_filt) else $error("lockout unfiltered");
  property p_hold;
    $fell(fault_flag_n_oe) |-> $past(sleep, 2) || $past(sleep, 3) || $past(supply_low_lockout);
  endproperty
  a_hold: assert property (p_hold) else $error("flag released early");
endmodule : bfp_top_properties

bind bfp_top bfp_top_properties #(.TSD_CYC(TSD_CYC), .SUPPLY_LOW_LOCKOUT_CYC(SUPPLY_LOW_LOCKOUT_CYC), .OSC_DIV(OSC_DIV))
  bfp_top_properties_inst (.sys_clk, .rst_n, .clk_en, .thermal_shutdown, .supply_low, .sleep,
  .osc_set_pin, .fault_flag_n_o, .fault_flag_n_oe, .thermal_flag_n_o, .thermal_flag_n_oe,
  .supply_low_lockout, .chop_tick, .gates_a, .gates_b);

// File: sim/tb_bfp_top.sv
// tb_bfp_top: bridge modes, fault latching, clearing and lockout
// assumes shortened filters and oscillator divide
`timescale 1ns/1ps
module tb_bfp_top;
  import bfp_pkg::*;
  localparam int unsigned THERMAL_SHUTDOWN = 4, OC = 3, UV = 3, OD = 4;
  logic       sys_clk = 1'b0, rst_n = 1'b0, bridge_enable = 1'b0, sleep = 1'b0;
  logic       clk_en = 1'b1, osc_set_pin = 1'b0, osc_ext_tick = 1'b0;
  logic       thermal_shutdown = 1'b0, supply_low = 1'b0, dir_a = 1'b0, dir_b = 1'b0;
  logic       overcurrent_detect_a = 1'b0, overcurrent_detect_b = 1'b0;
  logic       above_limit_a = 1'b0, above_limit_b = 1'b0, fast_phase_a = 1'b0;
  logic       fast_phase_b = 1'b0, fault_flag_n_o, fault_flag_n_oe, thermal_flag_n_o;
  logic       thermal_flag_n_oe, supply_low_lockout, chop_tick, fault_line, thermal_line;
  logic [3:0] gates_a, gates_b;
  int         error_cnt = 0, samples_checked = 0, cycles = 0;

  bfp_top #(.TSD_CYC(THERMAL_SHUTDOWN), .OC_CYC(OC), .SUPPLY_LOW_LOCKOUT_CYC(UV), .OSC_DIV(OD)) bfp_top_inst (
    .sys_clk, .rst_n, .clk_en, .thermal_shutdown, .overcurrent_detect_a,
    .overcurrent_detect_b, .supply_low, .sleep, .osc_set_pin, .osc_ext_tick,
    .bridge_enable, .dir_a, .dir_b, .above_limit_a, .above_limit_b, .fast_phase_a,
    .fast_phase_b, .fault_flag_n_o, .fault_flag_n_oe, .thermal_flag_n_o, .thermal_flag_n_oe,
    .supply_low_lockout, .chop_tick, .gates_a, .gates_b);
  bfp_load_model bfp_load_model_inst (.fault_flag_n_o, .fault_flag_n_oe, .thermal_flag_n_o,
    .thermal_flag_n_oe, .fault_line, .thermal_line);

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task chk_n(input int got, input int exp, input string what);
    samples_checked++;
    if (got != exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : chk_n
  task flags(input logic f, input logic t);
    chk({3'h0, fault_line}, {3'h0, f}, "fault line");
    chk({3'h0, thermal_line}, {3'h0, t}, "thermal line");
  endtask : flags
  function automatic logic [3:0] want(input logic d, input int m);
    if (m == 2) return 4'hc;
    return ((m == 0) ^ d) ? 4'h9 : 4'h6;
  endfunction : want
  task wait_chop;
    int i;
    i = 0;
    while (chop_tick !== 1'b1 && i < 200) begin
      tick(1);
      i++;
    end
    chk({3'h0, chop_tick}, 4'h1, "chop tick");
  endtask : wait_chop
  task t_clear;
    sleep = 1'b1;
    tick(4);
    sleep = 1'b0;
    tick(40);
  endtask : t_clear
  task t_modes;
    for (int d = 0; d < 2; d++) begin
      for (int m = 0; m < 3; m++) begin
        dir_a = d[0];
        dir_b = !d[0];
        {above_limit_a, above_limit_b} = {2{m != 0}};
        {fast_phase_a, fast_phase_b} = {2{m == 1}};
        wait_chop();
        tick(50);
        chk(gates_a, want(d[0], m), "gates a");
        chk(gates_b, want(!d[0], m), "gates b");
      end
    end
  endtask : t_modes
  task t_thermal;
    thermal_shutdown = 1'b1;
    tick(THERMAL_SHUTDOWN - 1);
    thermal_shutdown = 1'b0;
    tick(10);
    flags(1'b1, 1'b1);
    thermal_shutdown = 1'b1;
    tick(THERMAL_SHUTDOWN + 6);
    flags(1'b0, 1'b0);
    chk(gates_a | gates_b, 4'h0, "gates");
    thermal_shutdown = 1'b0;
    tick(20);
    flags(1'b0, 1'b0);
    t_clear();
    flags(1'b1, 1'b1);
  endtask : t_thermal
  task t_overcurrent;
    wait_chop();
    tick(30);
    chk(gates_a, 4'hc, "gates a");
    overcurrent_detect_a = 1'b1;
    tick(OC - 1);
    overcurrent_detect_a = 1'b0;
    tick(10);
    flags(1'b1, 1'b1);
    overcurrent_detect_b = 1'b1;
    tick(OC + 6);
    overcurrent_detect_b = 1'b0;
    flags(1'b0, 1'b1);
    chk(gates_a | gates_b, 4'h0, "gates");
    tick(10);
    flags(1'b0, 1'b1);
  endtask : t_overcurrent
  task t_lockout;
    supply_low = 1'b1;
    tick(UV - 1);
    supply_low = 1'b0;
    tick(5);
    chk({3'h0, supply_low_lockout}, 4'h0, "lockout");
    supply_low = 1'b1;
    tick(UV + 5);
    chk({3'h0, supply_low_lockout}, 4'h1, "lockout");
    chk(gates_a | gates_b, 4'h0, "gates");
    flags(1'b1, 1'b1);
    supply_low = 1'b0;
    tick(10);
    chk({3'h0, supply_low_lockout}, 4'h0, "lockout");
    flags(1'b1, 1'b1);
  endtask : t_lockout

  task t_ext_osc;
    int t0, gap;
    t0 = -1;
    gap = 0;
    osc_set_pin = 1'b1;
    tick(3);
    for (int n = 0; n < 300 && gap == 0; n++) begin
      osc_ext_tick = n[1];
      tick(1);
      if (chop_tick === 1'b1) begin
        if (t0 >= 0) gap = n - t0;
        t0 = n;
      end
    end
    chk_n(gap, CHOP_DIV * 4, "external chop gap");
    osc_ext_tick = 1'b0;
    tick(3);
    osc_set_pin = 1'b0;
    tick(3);
  endtask : t_ext_osc
  task t_freeze;
    int ticks;
    ticks = 0;
    wait_chop();
    tick(30);
    clk_en = 1'b0;
    repeat (100) begin
      tick(1);
      if (chop_tick === 1'b1) ticks++;
    end
    chk(gates_a, 4'hc, "frozen gates a");
    chk_n(ticks, 0, "frozen chop ticks");
    clk_en = 1'b1;
  endtask : t_freeze
  task t_reapply;
    thermal_shutdown = 1'b1;
    tick(THERMAL_SHUTDOWN + 6);
    thermal_shutdown = 1'b0;
    flags(1'b0, 1'b0);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(1);
    flags(1'b1, 1'b1);
    chk(gates_a | gates_b, 4'h0, "gates after reset");
    tick(40);
    chk(gates_a, want(1'b1, 2), "gates a resumed");
  endtask : t_reapply

  initial begin
    tick(6);
    rst_n = 1'b1;
    bridge_enable = 1'b1;
    tick(2);
    t_modes();
    t_ext_osc();
    t_freeze();
    t_thermal();
    t_overcurrent();
    t_lockout();
    t_reapply();
    summarize();
  end
endmodule : tb_bfp_top
